// File: include/periph_bridge_defs.svh
// Behaviour
// - Strobe-0 multiplier is four read/write bits 3:0 of control, reset 0x1.
// - Region-0 accesses stretch the strobe to a multiple of the bridge clock.
// - Code n gives 2*n bridge clocks; code zero acts as code one.
// - Stretching is counted on the bridge clock, equal to the traffic clock.
// - Initiator-priority bit 5 of allocation register, read/write, reset 0.
// - Fixed priority: bit 0 grants DMA first, bit 1 grants initiator port.
// - Scheme bit 4, reset 0: 0 round-robin, 1 fixed priority.
`ifndef PERIPH_BRIDGE_DEFS_SVH
`define PERIPH_BRIDGE_DEFS_SVH

// ==========================================================
// Register map (byte addresses)
`define OFS_STROBE_CTRL 8'h00
`define OFS_BUS_ALLOC 8'h04
`define OFS_ARB_STATUS 8'h10

// ==========================================================
// Field positions
`define MULT_LSB 0
`define MULT_MSB 3
`define SCHEME_BIT 4
`define PRIO_BIT 5
`define ST_BUSY_BIT 0
`define ST_OWNER_BIT 1
`define ST_LAST_BIT 2
`define ST_LEN_LSB 8
`define ST_LEN_MSB 12

// ==========================================================
// Reset values
`define MULT_RST 4'h1
`define SCHEME_RST 1'b0
`define PRIO_RST 1'b0

// ==========================================================
// Strobe timing
`define MULT_ZERO 4'h0
`define MULT_ONE 4'h1
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01

`endif

// File: include/periph_bridge_pkg.sv
// ==========================================================
// Shared types
package periph_bridge_pkg;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_STROBE = 1'b1
   } bridge_state_t;

   typedef enum logic [0:0] {
      OWN_DMA = 1'b0,
      OWN_INIT = 1'b1
   } owner_t;

endpackage : periph_bridge_pkg

// File: core/periph_bridge.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "periph_bridge_defs.svh"

module periph_bridge
   import periph_bridge_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Upstream requesters
   input wire logic dma_req_i,
   input wire logic init_req_i,
   output logic dma_gnt_o,
   output logic init_gnt_o,
   output logic acc_done_o,
   // Peripheral bus strobe region 0
   output logic per_strobe0_o
);

   // ==========================================================
   // Registers
   logic [3:0] strobe0_multiplier_q;
   logic arb_scheme_sel_q;
   logic initiator_priority_sel_q;
   logic ack_q;
   logic [31:0] rdata_q;
   bridge_state_t state_q;
   owner_t owner_q;
   owner_t last_q;
   logic [4:0] cnt_q;
   logic [4:0] len_q;
   logic wb_req;
   logic wb_wr;
   logic [31:0] rdata_d;
   logic [3:0] eff_mult;
   logic [4:0] len_d;
   owner_t win_d;

   // ==========================================================
   // Wishbone handshake
   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wb_wr = wb_req && wb_we_i && ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req && !ack_q;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
         `OFS_STROBE_CTRL: begin
            rdata_d[`MULT_MSB:`MULT_LSB] = strobe0_multiplier_q;
         end
         `OFS_BUS_ALLOC: begin
            rdata_d[`SCHEME_BIT] = arb_scheme_sel_q;
            rdata_d[`PRIO_BIT] = initiator_priority_sel_q;
         end
         `OFS_ARB_STATUS: begin
            rdata_d[`ST_BUSY_BIT] = (state_q == ST_STROBE);
            rdata_d[`ST_OWNER_BIT] = owner_q;
            rdata_d[`ST_LAST_BIT] = last_q;
            rdata_d[`ST_LEN_MSB:`ST_LEN_LSB] = len_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (wb_req && !ack_q && !wb_we_i) begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe0_multiplier_q <= `MULT_RST;
      end else if (wb_wr && wb_adr_i == `OFS_STROBE_CTRL && wb_sel_i[0]) begin
         strobe0_multiplier_q <= wb_dat_i[`MULT_MSB:`MULT_LSB];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arb_scheme_sel_q <= `SCHEME_RST;
         initiator_priority_sel_q <= `PRIO_RST;
      end else if (wb_wr && wb_adr_i == `OFS_BUS_ALLOC && wb_sel_i[0]) begin
         arb_scheme_sel_q <= wb_dat_i[`SCHEME_BIT];
         initiator_priority_sel_q <= wb_dat_i[`PRIO_BIT];
      end
   end

   // ==========================================================
   // Arbitration
   always_comb begin
      win_d = OWN_DMA;
      if (dma_req_i && init_req_i) begin
         if (arb_scheme_sel_q) begin
            win_d = initiator_priority_sel_q ? OWN_INIT : OWN_DMA;
         end else begin
            win_d = (last_q == OWN_DMA) ? OWN_INIT : OWN_DMA;
         end
      end else if (init_req_i) begin
         win_d = OWN_INIT;
      end
   end

   // Strobe length, code zero folded onto code one
   assign eff_mult = (strobe0_multiplier_q == `MULT_ZERO) ? `MULT_ONE
                                                          : strobe0_multiplier_q;
   assign len_d = {eff_mult, 1'b0};

   // ==========================================================
   // Access sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         owner_q <= OWN_DMA;
         last_q <= OWN_INIT;
         cnt_q <= `CNT_ZERO;
         len_q <= `CNT_ZERO;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (dma_req_i || init_req_i) begin
                  state_q <= ST_STROBE;
                  owner_q <= win_d;
                  last_q <= win_d;
                  len_q <= len_d;
                  cnt_q <= len_d - `CNT_ONE;
               end
            end
            ST_STROBE: begin
               if (cnt_q == `CNT_ZERO) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - `CNT_ONE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign per_strobe0_o = (state_q == ST_STROBE);
   assign dma_gnt_o = (state_q == ST_STROBE) && (owner_q == OWN_DMA);
   assign init_gnt_o = (state_q == ST_STROBE) && (owner_q == OWN_INIT);
   assign acc_done_o = (state_q == ST_STROBE) && (cnt_q == `CNT_ZERO);

   // ==========================================================
   // Checks
   logic [5:0] run_q;
   logic [3:0] start_mult_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 6'h00;
         start_mult_q <= 4'h0;
      end else begin
         run_q <= per_strobe0_o ? run_q + 6'h01 : 6'h00;
         if (state_q == ST_IDLE && (dma_req_i || init_req_i)) begin
            start_mult_q <= strobe0_multiplier_q;
         end
      end
   end

   property p_mult_reset;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> strobe0_multiplier_q == `MULT_RST;
   endproperty
   a_mult_reset: assert property (p_mult_reset)
      else $error("multiplier not 1 after reset");

   property p_strobe_len;
      @(posedge clk_i) disable iff (rst_i)
      $fell(per_strobe0_o) |-> {1'b0, $past(len_q)} == run_q;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe length differs from latched length");

   property p_double;
      @(posedge clk_i) disable iff (rst_i)
      $fell(per_strobe0_o) && start_mult_q != 4'h0
         |-> run_q == {1'b0, start_mult_q, 1'b0};
   endproperty
   a_double: assert property (p_double)
      else $error("strobe not twice the code");

   property p_zero;
      @(posedge clk_i) disable iff (rst_i)
      $fell(per_strobe0_o) && start_mult_q == 4'h0 |-> run_q == 6'h02;
   endproperty
   a_zero: assert property (p_zero)
      else $error("code zero not two cycles");

   property p_max;
      @(posedge clk_i) disable iff (rst_i)
      run_q <= 6'h1E;
   endproperty
   a_max: assert property (p_max)
      else $error("strobe longer than thirty cycles");

   property p_alloc_reset;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> !initiator_priority_sel_q && !arb_scheme_sel_q;
   endproperty
   a_alloc_reset: assert property (p_alloc_reset)
      else $error("allocation bits not zero after reset");

   property p_fixed;
      @(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && dma_req_i && init_req_i && arb_scheme_sel_q
         |=> (init_gnt_o == $past(initiator_priority_sel_q))
             && (dma_gnt_o != $past(initiator_priority_sel_q));
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed priority grant wrong");

   property p_rr;
      @(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && dma_req_i && init_req_i && !arb_scheme_sel_q
         |=> owner_q != $past(last_q);
   endproperty
   a_rr: assert property (p_rr)
      else $error("round robin did not alternate");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      per_strobe0_o && $past(per_strobe0_o) |-> $stable(len_q) && $stable(owner_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("access length changed mid access");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");

   property p_ack_answer;
      @(posedge clk_i) disable iff (rst_i)
      wb_req && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("bus request not answered next cycle");

   property p_ctrl_write;
      @(posedge clk_i) disable iff (rst_i)
      wb_wr && wb_adr_i == `OFS_STROBE_CTRL && wb_sel_i[0]
         |=> strobe0_multiplier_q == $past(wb_dat_i[`MULT_MSB:`MULT_LSB]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("multiplier write lost");

   property p_alloc_write;
      @(posedge clk_i) disable iff (rst_i)
      wb_wr && wb_adr_i == `OFS_BUS_ALLOC && wb_sel_i[0]
         |=> initiator_priority_sel_q == $past(wb_dat_i[`PRIO_BIT])
             && arb_scheme_sel_q == $past(wb_dat_i[`SCHEME_BIT]);
   endproperty
   a_alloc_write: assert property (p_alloc_write)
      else $error("allocation write lost");

   property p_grant;
      @(posedge clk_i) disable iff (rst_i)
      per_strobe0_o == (dma_gnt_o ^ init_gnt_o);
   endproperty
   a_grant: assert property (p_grant)
      else $error("grant does not match strobe");

   property p_start;
      @(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && (dma_req_i || init_req_i) |=> per_strobe0_o;
   endproperty
   a_start: assert property (p_start)
      else $error("access did not start strobe");

   c_long: cover property (@(posedge clk_i) disable iff (rst_i)
      $fell(per_strobe0_o) && run_q == 6'h1E);
   c_both_fixed: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && dma_req_i && init_req_i && arb_scheme_sel_q);
   c_both_rr: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && dma_req_i && init_req_i && !arb_scheme_sel_q);
   c_zero_code: cover property (@(posedge clk_i) disable iff (rst_i)
      $fell(per_strobe0_o) && start_mult_q == 4'h0);
   c_mid_write: cover property (@(posedge clk_i) disable iff (rst_i)
      per_strobe0_o && wb_wr && wb_adr_i == `OFS_STROBE_CTRL);

endmodule : periph_bridge

// File: sim/periph_slave_model.sv
`timescale 1ns/100ps

// ==========================================================
// Slow peripheral on strobe region 0: measures each strobe
module periph_slave_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Strobe from bridge
   input wire logic per_strobe0_i,
   // Length of the last finished strobe, in clocks
   output logic [5:0] last_len_o
);
   logic [5:0] run_q;

   // Counts strobe cycles on the shared bridge clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 6'h00;
         last_len_o <= 6'h00;
      end else if (per_strobe0_i) begin
         run_q <= run_q + 6'h01;
      end else begin
         if (run_q != 6'h00) begin
            last_len_o <= run_q;
         end
         run_q <= 6'h00;
      end
   end
endmodule : periph_slave_model

// File: sim/periph_bridge_tb.sv
`timescale 1ns/100ps

module periph_bridge_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdata;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat_o;
   logic ack, dma_req = 1'b0, init_req = 1'b0;
   logic dma_gnt, init_gnt, done, strobe;
   logic [5:0] last_len;
   logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h8, 4'hF};
   int n_fail = 0;
   int total_checks = 0;

   always #5 clk_i = ~clk_i;

   periph_bridge #(.ADDR_W(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .dma_req_i(dma_req), .init_req_i(init_req),
      .dma_gnt_o(dma_gnt), .init_gnt_o(init_gnt), .acc_done_o(done),
      .per_strobe0_o(strobe));

   periph_slave_model u_per (.clk_i(clk_i), .rst_i(rst_i), .per_strobe0_i(strobe),
      .last_len_o(last_len));

   // ==========================================================
   // Verdict
   task report_and_stop;
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic bound(input int k);
      if (k >= 40) begin
         n_fail++;
         report_and_stop;
      end
   endtask : bound

   // ==========================================================
   // Wishbone classic cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      bound(k);
      rdata = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // ==========================================================
   // One requester access with grant and length checks
   task automatic acc(input logic d, input logic i, input logic exp_dma, input logic [5:0] len);
      int k;
      @(posedge clk_i);
      dma_req <= d;
      init_req <= i;
      for (k = 0; k < 40; k++) begin
         @(negedge clk_i);
         if (strobe === 1'b1) break;
      end
      bound(k);
      chk("dma_gnt", {31'h0, exp_dma}, {31'h0, dma_gnt});
      chk("init_gnt", {31'h0, !exp_dma}, {31'h0, init_gnt});
      for (k = 0; k < 40; k++) begin
         if (done === 1'b1) break;
         @(negedge clk_i);
      end
      bound(k);
      chk("strobe_at_done", 32'h1, {31'h0, strobe});
      @(posedge clk_i);
      dma_req <= 1'b0;
      init_req <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("strobe_len", {26'h0, len}, {26'h0, last_len});
   endtask : acc

   // ==========================================================
   // Sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl_rst", 32'h1, rdata);
      wb(1'b0, 8'h04, 32'h0);
      chk("alloc_rst", 32'h0, rdata);
      wb(1'b0, 8'h10, 32'h0);
      chk("status_rst", 32'h0000_0004, rdata);
      acc(1'b1, 1'b1, 1'b1, 6'h02);
      acc(1'b1, 1'b1, 1'b0, 6'h02);
      wb(1'b1, 8'h04, 32'h10);
      acc(1'b1, 1'b1, 1'b1, 6'h02);
      acc(1'b1, 1'b1, 1'b1, 6'h02);
      wb(1'b1, 8'h04, 32'h30);
      wb(1'b0, 8'h04, 32'h0);
      chk("alloc_rw", 32'h30, rdata);
      acc(1'b1, 1'b1, 1'b0, 6'h02);
      for (int j = 0; j < 4; j++) begin
         wb(1'b1, 8'h00, {28'h0, codes[j]});
         wb(1'b0, 8'h00, 32'h0);
         chk("ctrl_rw", {28'h0, codes[j]}, rdata);
         acc(1'b1, 1'b0, 1'b1, (codes[j] == 4'h0) ? 6'h02 : {1'b0, codes[j], 1'b0});
      end
      wb(1'b1, 8'h00, 32'h2);
      fork
         acc(1'b0, 1'b1, 1'b0, 6'h04);
         begin
            @(posedge clk_i);
            wb(1'b1, 8'h00, 32'h5);
         end
      join
      acc(1'b0, 1'b1, 1'b0, 6'h0A);
      wb(1'b0, 8'h10, 32'h0);
      chk("status_len", 32'h0000_0A06, rdata);
      wb(1'b1, 8'h08, 32'hFFFF);
      wb(1'b0, 8'h08, 32'h0);
      chk("unmapped", 32'h0, rdata);
      sel <= 4'hE;
      wb(1'b1, 8'h00, 32'h7);
      sel <= 4'hF;
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl_sel", 32'h5, rdata);
      report_and_stop;
   end
endmodule : periph_bridge_tb
